// File: logic/usc_defines.vh
/*
 Register offsets, field positions, reset values and timing counts for the
 serial port control block. Assumes inclusion by bare name from logic/.
*/
`ifndef USC_DEFINES_VH
`define USC_DEFINES_VH
// ****************************************
// Register map
// ****************************************
`define USC_ADDR_CTRL 8'h98
`define USC_ADDR_BUF 8'h99
`define USC_CTRL_RESET 8'h00
// ****************************************
// Control fields
// ****************************************
`define USC_MODE_HI 7
`define USC_MODE_LO 6
`define USC_MP_EN 5
`define USC_RX_EN 4
`define USC_TX_B8 3
`define USC_RX_B8 2
`define USC_TX_DONE 1
`define USC_RX_DONE 0
`define USC_MODE_SHIFT 2'h0
`define USC_MODE_8VAR 2'h1
`define USC_MODE_9FIX 2'h2
`define USC_MODE_9VAR 2'h3
// ****************************************
// Timing
// ****************************************
`define USC_SYSCLK_MHZ 50
`define USC_DIV_SHIFT 8'h01
`define USC_DIV_FIX_SLOW 8'h03
`define USC_DIV_FIX_FAST 8'h01
`endif

// File: logic/usc_bit_timer.v
/*
 Bit-rate enable generator: one-cycle pulse every divide+1 clocks.
 Assumes the divide value is stable while running.
*/
module usc_bit_timer (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control
  input wire run,
  input wire [7:0] divide,
  // Pulse out
  output reg tick
);
  reg [7:0] cnt_r;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= 8'h00;
      tick <= 1'b0;
    end
    else if (cnt_r == divide)
    begin
      cnt_r <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule

// File: logic/usc_serial_port.v
/*
 Serial port control and status with a simple shift engine per direction.
 Assumes a single-cycle special function register bus and synchronous pins.
*/
// Summary of operation
// - Mode 00 is shift register at clk/2.
// - Filter on, 9-bit: drop flag if bit8 zero.
// - Filter on, mode 01: need valid stop.
// - Filter separates address frames from data frames in 9-bit modes.
// - Shift mode: tx flag after eighth bit.
// - Async modes: tx flag at stop start.
// - Only software clears tx flag.
// - Rx flag at end; only software clears.
// - One data address; separate tx/rx storage.
`include "usc_defines.vh"
module usc_serial_port (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register bus
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  input wire [7:0] varDivide,
  input wire fixFast,
  output reg [7:0] regRdata,
  // Serial line
  input wire rxdIn,
  output reg txdOut,
  output reg rxdOut,
  output reg rxdOen,
  output reg shiftClk
);
  // ****************************************
  // Control register
  // ****************************************
  reg [7:0] ctrl_r;
  reg [7:0] rxBuf_r;
  reg [10:0] txSh_r;
  reg [3:0] txCnt_r;
  reg [3:0] txPh_r;
  reg txBusy_r;
  reg [8:0] rxSh_r;
  reg [3:0] rxCnt_r;
  reg [3:0] rxPh_r;
  reg rxBusy_r;
  reg rxPrev_r;
  reg txSet, rxSet, rxB8Set, rxB8Val;
  wire [1:0] mode = {ctrl_r[`USC_MODE_HI], ctrl_r[`USC_MODE_LO]};
  wire shiftMode = (mode == `USC_MODE_SHIFT);
  wire nineBit = mode[1];
  wire wrCtrl = regWrite && (regAddr == `USC_ADDR_CTRL);
  wire wrBuf = regWrite && (regAddr == `USC_ADDR_BUF);
  wire rxStart = ctrl_r[`USC_RX_EN] && !rxBusy_r;
  reg [7:0] divide;
  wire tick;
  wire sampleTick;
  always @*
  begin
    case (mode)
      `USC_MODE_SHIFT: divide = `USC_DIV_SHIFT;
      `USC_MODE_9FIX: divide = fixFast ? `USC_DIV_FIX_FAST : `USC_DIV_FIX_SLOW;
      default: divide = varDivide;
    endcase
  end
  usc_bit_timer uTimer (
    .clk(clk),
    .resetn(resetn),
    .run(txBusy_r || rxBusy_r),
    .divide(divide),
    .tick(tick)
  );
  // Shift mode steps every clock for a clk/2 shift clock; async receive samples 16 per bit.
  assign sampleTick = shiftMode || tick;
  // ****************************************
  // Flags and registers
  // ****************************************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl_r <= `USC_CTRL_RESET;
    else
    begin
      if (wrCtrl)
        ctrl_r <= regWdata;
      // Hardware set wins over a software clear in the same cycle.
      if (txSet)
        ctrl_r[`USC_TX_DONE] <= 1'b1;
      if (rxSet)
        ctrl_r[`USC_RX_DONE] <= 1'b1;
      if (rxB8Set)
        ctrl_r[`USC_RX_B8] <= rxB8Val;
    end
  end
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `USC_ADDR_CTRL: regRdata <= ctrl_r;
        `USC_ADDR_BUF: regRdata <= rxBuf_r;
        default: regRdata <= 8'h00;
      endcase
    end
  end
  // ****************************************
  // Transmit
  // ****************************************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txSh_r <= 11'h7ff;
      txPh_r <= 4'h0;
      txCnt_r <= 4'h0;
      txBusy_r <= 1'b0;
      txdOut <= 1'b1;
      txSet <= 1'b0;
    end
    else
    begin
      txSet <= 1'b0;
      if (wrBuf && !txBusy_r)
      begin
        // Frame: start, eight data, ninth or stop, stop; shift mode sends data only.
        if (shiftMode)
          txSh_r <= {3'h7, regWdata};
        else
          txSh_r <= {1'b1, (nineBit ? ctrl_r[`USC_TX_B8] : 1'b1), regWdata, 1'b0};
        txCnt_r <= 4'h0;
        txPh_r <= 4'h0;
        txBusy_r <= 1'b1;
      end
      else if (txBusy_r && tick)
      begin
        // Own bit phase, so sending never waits on the receiver being busy.
        txPh_r <= txPh_r + 4'h1;
        if (shiftMode || txPh_r == 4'hf)
        begin
          txdOut <= txSh_r[0];
          txSh_r <= {1'b1, txSh_r[10:1]};
          txCnt_r <= txCnt_r + 4'h1;
          if (shiftMode && txCnt_r == 4'h8)
          begin
            txSet <= 1'b1;
            txBusy_r <= 1'b0;
          end
          else if (!shiftMode && txCnt_r == (nineBit ? 4'ha : 4'h9))
            txSet <= 1'b1;
          else if (!shiftMode && txCnt_r == (nineBit ? 4'hb : 4'ha))
            txBusy_r <= 1'b0;
        end
      end
    end
  end
  // ****************************************
  // Receive
  // ****************************************
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxSh_r <= 9'h000;
      rxCnt_r <= 4'h0;
      rxPh_r <= 4'h0;
      rxBusy_r <= 1'b0;
      rxPrev_r <= 1'b1;
      rxBuf_r <= 8'h00;
      rxSet <= 1'b0;
      rxB8Set <= 1'b0;
      rxB8Val <= 1'b0;
      rxdOut <= 1'b1;
      rxdOen <= 1'b1;
      shiftClk <= 1'b1;
    end
    else
    begin
      rxSet <= 1'b0;
      rxB8Set <= 1'b0;
      rxPrev_r <= rxdIn;
      if (!rxBusy_r)
      begin
        rxPh_r <= 4'h0;
        rxCnt_r <= 4'h0;
        rxdOen <= 1'b1;
        if (rxStart && (shiftMode ? (!ctrl_r[`USC_RX_DONE] && !rxSet) : (rxPrev_r && !rxdIn)))
        begin
          rxBusy_r <= 1'b1;
          rxdOen <= !shiftMode;
        end
      end
      else if (sampleTick)
      begin
        if (shiftMode)
        begin
          shiftClk <= !shiftClk;
          if (!shiftClk)
          begin
            rxSh_r <= {rxdIn, rxSh_r[8:1]};
            rxCnt_r <= rxCnt_r + 4'h1;
            if (rxCnt_r == 4'h7)
            begin
              rxBuf_r <= {rxdIn, rxSh_r[8:2]};
              rxSet <= 1'b1;
              rxBusy_r <= 1'b0;
              shiftClk <= 1'b1;
            end
          end
        end
        else
        begin
          rxPh_r <= rxPh_r + 4'h1;
          if (rxPh_r == 4'h7)
          begin
            rxCnt_r <= rxCnt_r + 4'h1;
            rxSh_r <= {rxdIn, rxSh_r[8:1]};
            if (rxCnt_r == 4'h0 && rxdIn)
              rxBusy_r <= 1'b0;
            else if (rxCnt_r == (nineBit ? 4'ha : 4'h9))
            begin
              rxBusy_r <= 1'b0;
              // Address filtering sets the flag only for frames with the ninth bit set, or in mode 01 with a valid stop.
              if (!ctrl_r[`USC_RX_DONE] &&
                  !(ctrl_r[`USC_MP_EN] && nineBit && !rxSh_r[8]) &&
                  !(ctrl_r[`USC_MP_EN] && !nineBit && !rxdIn))
              begin
                rxBuf_r <= nineBit ? rxSh_r[7:0] : rxSh_r[8:1];
                rxSet <= 1'b1;
                rxB8Set <= 1'b1;
                rxB8Val <= nineBit ? rxSh_r[8] : rxdIn;
              end
            end
          end
        end
      end
    end
  end
endmodule

// File: bench/usc_remote_node.sv
/*
 Remote node on the serial line: sends frames to the port, captures its frames.
 Assumes bitClks clocks per bit; 16 matches a divider reload of zero.
*/
module usc_remote_node (
  // Clock
  input wire clk,
  // Line
  input wire txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] got;
  int frames;
  int bitClks = 16;
  initial rxd = 1'b1;
  // Start bit, nine bits LSB first, then stop; the line idles high.
  task automatic send(input logic [8:0] f);
    for (int i = 0; i < 11; i++)
    begin
      rxd <= (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : f[i-1];
      repeat (bitClks) @(posedge clk);
    end
  endtask
  // Mid-bit sampling tolerates a few clocks of skew at each edge.
  always @(negedge txd)
  begin
    repeat (bitClks / 2) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bitClks) @(posedge clk);
      got[i] = txd;
    end
    frames++;
  end
endmodule

// File: bench/usc_serial_port_monitor.sv
/*
 Port checker for the serial port block.
 Assumes one clock domain with the async active-low reset.
*/
`include "usc_defines.vh"
module usc_serial_port_monitor (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Register bus
  input wire [7:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  // Serial line
  input wire txdOut,
  input wire rxdOut,
  input wire shiftClk
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd1, rd2;
  logic [1:0] seen;
  logic [1:0] modeSeen;
  // Flags seen set stay set in later reads until software writes control.
  always @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      rd1 <= 1'b0;
      rd2 <= 1'b0;
      seen <= 2'h0;
      modeSeen <= 2'h0;
    end
    else
    begin
      rd1 <= regRead && !regWrite && regAddr == `USC_ADDR_CTRL;
      rd2 <= rd1;
      if (regWrite && regAddr == `USC_ADDR_CTRL)
      begin
        seen <= 2'h0;
        modeSeen <= regWdata[7:6];
      end
      else if (rd2)
        seen <= seen | regRdata[1:0];
    end
  sequence sWrCtrl;
    regWrite && regAddr == `USC_ADDR_CTRL;
  endsequence
  sequence sRdCtrl;
    regRead && !regWrite && regAddr == `USC_ADDR_CTRL;
  endsequence
  a_ctrl_echo: assert property (sWrCtrl ##1 sRdCtrl |=> ##1
    regRdata[7:3] == $past(regWdata[7:3], 3)) else $error("control echo wrong");
  a_rdata_hold: assert property (!$past(regRead) |-> $stable(regRdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (regRead && regAddr != `USC_ADDR_CTRL &&
    regAddr != `USC_ADDR_BUF |=> ##1 regRdata == 8'h00) else $error("unmapped not zero");
  a_tx_sticky: assert property (rd2 && seen[1] |-> regRdata[1])
    else $error("tx flag lost");
  a_rx_sticky: assert property (rd2 && seen[0] |-> regRdata[0])
    else $error("rx flag lost");
  // Shift mode bits last two clocks, so only the framed modes are held to a long start bit.
  a_start_low: assert property (modeSeen != 2'h0 && $fell(txdOut) |-> !txdOut [*8])
    else $error("start bit short");
  a_shift_idle: assert property (!txdOut |-> shiftClk)
    else $error("shift clock not idle");
  a_rxd_high: assert property (rxdOut)
    else $error("rxd output low");
endmodule

// File: bench/usc_tb.sv
/*
 Self-checking bench: register tasks and a remote node on the line.
 Assumes the design header is on the include path.
*/
`include "usc_defines.vh"
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, regWrite, regRead, txdOut, rxdOut, rxdOen, shiftClk, rxdIn, fixFast;
  logic [7:0] regAddr, regWdata, regRdata, v;
  int err_count, checks_done, cyc;
  usc_serial_port usc_serial_port_inst (.clk, .resetn, .regAddr, .regWrite, .regRead,
    .regWdata, .varDivide(8'h00), .fixFast, .regRdata, .rxdIn, .txdOut, .rxdOut,
    .rxdOen, .shiftClk);
  usc_remote_node usc_remote_node_inst (.clk, .txd(txdOut), .rxd(rxdIn));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    repeat (2) @(posedge clk);
    v = regRdata;
  endtask
  task automatic t_reset;
    rd(`USC_ADDR_CTRL);
    `CHK("ctrl reset", `USC_CTRL_RESET, v)
    rd(8'h00);
    `CHK("unmapped", 8'h00, v)
    $display("t_reset done");
  endtask
  task automatic t_tx;
    int n;
    n = usc_remote_node_inst.frames;
    wr(`USC_ADDR_CTRL, 8'hc8);
    rd(`USC_ADDR_CTRL);
    `CHK("ctrl", 8'hc8, v)
    wr(`USC_ADDR_BUF, 8'ha5);
    for (int i = 0; i < 400 && usc_remote_node_inst.frames == n; i++)
      @(posedge clk);
    `CHK("tx frame", 10'h3a5, usc_remote_node_inst.got)
    rd(`USC_ADDR_CTRL);
    `CHK("tx flag", 8'hca, v)
    repeat (40) @(posedge clk);
    rd(`USC_ADDR_CTRL);
    `CHK("tx flag held", 8'hca, v)
    wr(`USC_ADDR_CTRL, 8'hc8);
    rd(`USC_ADDR_CTRL);
    `CHK("tx flag clear", 8'hc8, v)
    $display("t_tx done");
  endtask
  task automatic t_rx;
    wr(`USC_ADDR_CTRL, 8'hf0);
    usc_remote_node_inst.send(9'h033);
    rd(`USC_ADDR_CTRL);
    `CHK("data frame", 8'hf0, v)
    usc_remote_node_inst.send(9'h15a);
    rd(`USC_ADDR_CTRL);
    `CHK("addr frame", 8'hf5, v)
    rd(`USC_ADDR_BUF);
    `CHK("rx data", 8'h5a, v)
    $display("t_rx done");
  endtask
  task automatic t_fix;
    int n;
    n = usc_remote_node_inst.frames;
    fixFast <= 1'b1;
    usc_remote_node_inst.bitClks = 32;
    wr(`USC_ADDR_CTRL, 8'h88);
    wr(`USC_ADDR_BUF, 8'h3c);
    for (int i = 0; i < 800 && usc_remote_node_inst.frames == n; i++)
      @(posedge clk);
    `CHK("fixed frame", 10'h33c, usc_remote_node_inst.got)
    rd(`USC_ADDR_CTRL);
    `CHK("fixed tx flag", 8'h8a, v)
    repeat (40) @(posedge clk);
    fixFast <= 1'b0;
    usc_remote_node_inst.bitClks = 16;
    $display("t_fix done");
  endtask
  task automatic t_rx8;
    wr(`USC_ADDR_CTRL, 8'h70);
    usc_remote_node_inst.send(9'h0c3);
    rd(`USC_ADDR_CTRL);
    `CHK("bad stop", 8'h70, v)
    usc_remote_node_inst.send(9'h1c3);
    rd(`USC_ADDR_CTRL);
    `CHK("good stop", 8'h75, v)
    rd(`USC_ADDR_BUF);
    `CHK("rx8 data", 8'hc3, v)
    $display("t_rx8 done");
  endtask
  task automatic t_shift;
    wr(`USC_ADDR_CTRL, 8'h00);
    wr(`USC_ADDR_BUF, 8'h96);
    rd(`USC_ADDR_CTRL);
    `CHK("shift busy", 8'h00, v)
    repeat (20) @(posedge clk);
    rd(`USC_ADDR_CTRL);
    `CHK("shift done", 8'h02, v)
    $display("t_shift done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // A hang in any wait ends the run as a mismatch.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      complete_run;
    end
  end
  initial
  begin
    resetn = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    fixFast = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_tx;
    t_fix;
    t_rx;
    t_rx8;
    t_shift;
    complete_run;
  end
endmodule
bind usc_serial_port usc_serial_port_monitor usc_serial_port_monitor_inst (.clk, .resetn,
  .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .txdOut, .rxdOut, .shiftClk);
